// File: design/scl_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes both sides on the same clock; DEPTH is a power of two.
`timescale 1ns/100ps
module scl_fifo
#(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic full
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------------
   assign full = (count_q == (AW+1)'(DEPTH));
   assign inReady = !full;
   assign outValid = (count_q != '0);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem_q[rdPtr_q];

   // Storage, no reset needed on the data words
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wrPtr_q] <= inData;
   end

   // Pointers and fill level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wrPtr_q <= wrPtr_q + 1'b1;
         if (pop)
            rdPtr_q <= rdPtr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule

// File: design/scl_line_skip.sv
// n-out-of-m line keep decision, taken at each line start.
// Assumes lineStart is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module scl_line_skip
(
   input wire logic clk,
   input wire logic rst,
   input wire logic lineStart,
   input wire logic [7:0] keepT,
   input wire logic [7:0] periodM,
   output logic keepLine
);
   logic [8:0] acc_q;
   logic keep_q;
   logic [8:0] keepN;
   logic [9:0] sum;
   logic bypass;

   // ----------------------------------------------------------------
   // Spread n kept lines evenly over each m scanned lines
   // ----------------------------------------------------------------
   assign keepN = 9'h100 - {1'b0, keepT};
   assign bypass = (keepT == 8'h00) || (periodM == 8'h00);
   assign sum = {1'b0, acc_q} + {1'b0, keepN};
   assign keepLine = keep_q;

   // Accumulator; n at or above m keeps every line
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         acc_q <= '0;
         keep_q <= 1'b1;
      end
      else if (lineStart)
      begin
         if (bypass || keepN >= {1'b0, periodM})
         begin
            acc_q <= '0;
            keep_q <= 1'b1;
         end
         else if (sum >= {2'b00, periodM})
         begin
            acc_q <= 9'(sum - {2'b00, periodM});
            keep_q <= 1'b1;
         end
         else
         begin
            acc_q <= sum[8:0];
            keep_q <= 1'b0;
         end
      end
   end
endmodule

// File: design/scl_pkg.sv
// Shared constants and types for the shading correction / line skip block.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz system clock.
package scl_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_OFS_HI = 10'h03E;
   localparam logic [9:0] IDX_OFS_LO = 10'h03F;
   localparam logic [9:0] IDX_GAIN_HI = 10'h040;
   localparam logic [9:0] IDX_GAIN_LO = 10'h041;
   localparam logic [9:0] IDX_SRC_CFG = 10'h042;
   localparam logic [9:0] IDX_KEEP_CNT = 10'h043;
   localparam logic [9:0] IDX_SKIP_PER = 10'h044;
   localparam logic [9:0] IDX_SKIP_AUX = 10'h054;
   localparam logic [9:0] IDX_STATUS = 10'h060;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CFG_BYPASS_BIT = 0;
   localparam int CFG_GAIN_SRC_BIT = 1;
   localparam int CFG_OFS_SRC_BIT = 2;
   localparam int AUX_LSB = 3;
   localparam int AUX_W = 5;
   localparam int GAIN_SHIFT = 14;
   localparam int ST_KEEP_BIT = 16;
   localparam int ST_FULL_BIT = 17;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_OFS_HI = 8'h00;
   localparam logic [7:0] RST_OFS_LO = 8'h00;
   localparam logic [7:0] RST_GAIN_HI = 8'h40;
   localparam logic [7:0] RST_GAIN_LO = 8'h00;
   localparam logic [7:0] RST_SRC_CFG = 8'h01;
   localparam logic [7:0] RST_KEEP_CNT = 8'h00;
   localparam logic [7:0] RST_SKIP_PER = 8'h00;
   localparam logic [7:0] RST_SKIP_AUX = 8'h00;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [15:0] offset;
      logic [15:0] gain;
   } scl_coef_t;

   typedef struct packed
   {
      logic lineFirst;
      logic [15:0] data;
   } scl_pix_t;

endpackage

// File: design/scl_shading_correct.sv
// Pixel-rate offset/gain correction with n-out-of-m line skipping.
// Assumes an AHB-Lite master on clk, a pixel source and a coefficient
// source on the same clock, and an image buffer draining the FIFO.
`timescale 1ns/100ps

// How it works
// - Fixed offset coefficient held as high and low byte registers.
// - Fixed gain coefficient held as high and low byte registers.
// - Enabled multiplier scales each pixel by coefficient over 16384.
// - A config bit bypasses the multiplier; pixels pass with no gain.
// - Gain source bit picks fixed register pair or per-pixel DRAM value.
// - Offset source bit picks fixed register pair or DRAM value.
// - Keep n equals 256 minus t lines out of every m scanned.
// - A keep value t of zero bypasses skipping; all lines saved.
// - A period m of zero bypasses skipping; all lines saved.
// - A five-bit field in bits 3 to 7 of a further register.
module scl_shading_correct
#(
   parameter int FIFO_DEPTH = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic lineStart,
   input wire logic pixValid,
   input wire logic [15:0] pixData,
   output logic pixReady,
   output logic [15:0] coefAddr,
   input wire logic coefValid,
   input wire scl_pkg::scl_coef_t coefIn,
   output logic coefReady,
   output logic outValid,
   output scl_pkg::scl_pix_t outPix,
   input wire logic outReady,
   output logic [4:0] lineSkipAux
);
   logic [7:0] ofsHi_q;
   logic [7:0] ofsLo_q;
   logic [7:0] gainHi_q;
   logic [7:0] gainLo_q;
   logic [7:0] srcCfg_q;
   logic [7:0] keepCnt_q;
   logic [7:0] skipPer_q;
   logic [7:0] skipAux_q;
   logic wrPend_q;
   logic [9:0] wrIdx_q;
   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic [15:0] pixPos_q;
   logic addrPhase;
   logic [9:0] addrIdx;
   logic bypassMul;
   logic gainFromDram;
   logic ofsFromDram;
   logic needCoef;
   logic coefOk;
   logic keepLine;
   logic fifoReady;
   logic fifoFull;
   logic roomOk;
   logic take;
   logic [15:0] ofsSel;
   logic [15:0] gainSel;
   logic [15:0] diff;
   logic [31:0] product;
   logic [17:0] scaled;
   scl_pkg::scl_pix_t corrPix;

   // ----------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdData_q;
   assign addrPhase = hsel && hready && (htrans == scl_pkg::HTRANS_NONSEQ);
   assign addrIdx = haddr[11:2];

   // Read data prepared in the address phase, shown in the data phase
   always_comb
   begin
      rdData_d = 32'h0000_0000;
      unique case (addrIdx)
         scl_pkg::IDX_OFS_HI: rdData_d[7:0] = ofsHi_q;
         scl_pkg::IDX_OFS_LO: rdData_d[7:0] = ofsLo_q;
         scl_pkg::IDX_GAIN_HI: rdData_d[7:0] = gainHi_q;
         scl_pkg::IDX_GAIN_LO: rdData_d[7:0] = gainLo_q;
         scl_pkg::IDX_SRC_CFG: rdData_d[7:0] = srcCfg_q;
         scl_pkg::IDX_KEEP_CNT: rdData_d[7:0] = keepCnt_q;
         scl_pkg::IDX_SKIP_PER: rdData_d[7:0] = skipPer_q;
         scl_pkg::IDX_SKIP_AUX: rdData_d[7:0] = skipAux_q;
         scl_pkg::IDX_STATUS:
         begin
            rdData_d[15:0] = pixPos_q;
            rdData_d[scl_pkg::ST_KEEP_BIT] = keepLine;
            rdData_d[scl_pkg::ST_FULL_BIT] = fifoFull;
         end
         default: rdData_d = 32'h0000_0000; // Unmapped reads as zero
      endcase
   end

   // Address phase capture for reads and pending writes
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPend_q <= 1'b0;
         wrIdx_q <= '0;
         rdData_q <= 32'h0000_0000;
      end
      else
      begin
         wrPend_q <= addrPhase && hwrite;
         if (addrPhase)
            wrIdx_q <= addrIdx;
         if (addrPhase && !hwrite)
            rdData_q <= rdData_d;
      end
   end

   // Register writes in the data phase; unmapped writes are dropped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ofsHi_q <= scl_pkg::RST_OFS_HI;
         ofsLo_q <= scl_pkg::RST_OFS_LO;
         gainHi_q <= scl_pkg::RST_GAIN_HI;
         gainLo_q <= scl_pkg::RST_GAIN_LO;
         srcCfg_q <= scl_pkg::RST_SRC_CFG;
         keepCnt_q <= scl_pkg::RST_KEEP_CNT;
         skipPer_q <= scl_pkg::RST_SKIP_PER;
         skipAux_q <= scl_pkg::RST_SKIP_AUX;
      end
      else if (wrPend_q)
      begin
         unique case (wrIdx_q)
            scl_pkg::IDX_OFS_HI: ofsHi_q <= hwdata[7:0];
            scl_pkg::IDX_OFS_LO: ofsLo_q <= hwdata[7:0];
            scl_pkg::IDX_GAIN_HI: gainHi_q <= hwdata[7:0];
            scl_pkg::IDX_GAIN_LO: gainLo_q <= hwdata[7:0];
            scl_pkg::IDX_SRC_CFG: srcCfg_q <= hwdata[7:0];
            scl_pkg::IDX_KEEP_CNT: keepCnt_q <= hwdata[7:0];
            scl_pkg::IDX_SKIP_PER: skipPer_q <= hwdata[7:0];
            scl_pkg::IDX_SKIP_AUX: skipAux_q <= {hwdata[7:3], 3'b000};
            default: ;
         endcase
      end
   end

   // Only bits 7..3 of the aux register exist; the rest read zero
   assign lineSkipAux = skipAux_q[scl_pkg::AUX_LSB +: scl_pkg::AUX_W];

   // ----------------------------------------------------------------
   // Source selection
   // ----------------------------------------------------------------
   assign bypassMul = srcCfg_q[scl_pkg::CFG_BYPASS_BIT];
   assign gainFromDram = srcCfg_q[scl_pkg::CFG_GAIN_SRC_BIT];
   assign ofsFromDram = srcCfg_q[scl_pkg::CFG_OFS_SRC_BIT];
   // A bypassed multiplier needs no gain word, so it does not wait on one
   assign needCoef = ofsFromDram || (gainFromDram && !bypassMul);
   assign ofsSel = ofsFromDram ? coefIn.offset : {ofsHi_q, ofsLo_q};
   assign gainSel = gainFromDram ? coefIn.gain : {gainHi_q, gainLo_q};

   // ----------------------------------------------------------------
   // Correction arithmetic
   // ----------------------------------------------------------------
   // Offset first, clamped at zero so dark pixels never wrap
   assign diff = (pixData > ofsSel) ? 16'(pixData - ofsSel) : 16'h0000;
   assign product = diff * gainSel;
   assign scaled = product[scl_pkg::GAIN_SHIFT +: 18];

   // Saturate the scaled value or pass the offset result unscaled
   always_comb
   begin
      corrPix.lineFirst = (pixPos_q == 16'h0000);
      if (bypassMul)
         corrPix.data = diff;
      else if (scaled[17:16] != 2'b00)
         corrPix.data = 16'hFFFF;
      else
         corrPix.data = scaled[15:0];
   end

   // ----------------------------------------------------------------
   // Stream handshake and pixel position
   // ----------------------------------------------------------------
   // Skipped lines are consumed without touching the FIFO
   assign coefOk = !needCoef || coefValid;
   assign roomOk = fifoReady || !keepLine;
   assign pixReady = coefOk && roomOk && !lineStart;
   assign take = pixValid && pixReady;
   // Coefficient word and pixel leave their sources together
   assign coefReady = needCoef && pixValid && roomOk && !lineStart;
   assign coefAddr = pixPos_q;

   // Position within the line, the DRAM coefficient index
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pixPos_q <= 16'h0000;
      else if (lineStart)
         pixPos_q <= 16'h0000;
      else if (take)
         pixPos_q <= pixPos_q + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Line skip decision and output buffer
   // ----------------------------------------------------------------
   scl_line_skip u_skip
   (
      .clk(clk),
      .rst(rst),
      .lineStart(lineStart),
      .keepT(keepCnt_q),
      .periodM(skipPer_q),
      .keepLine(keepLine)
   );

   scl_fifo
   #(
      .WIDTH($bits(scl_pkg::scl_pix_t)),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .clk(clk),
      .rst(rst),
      .inValid(take && keepLine),
      .inReady(fifoReady),
      .inData(corrPix),
      .outValid(outValid),
      .outReady(outReady),
      .outData(outPix),
      .full(fifoFull)
   );
endmodule

// File: verification/scl_dram_model.sv
// Coefficient source standing in for the external DRAM buffer.
// Same clock as the block; coefficients are a function of position.
`timescale 1ns/100ps
module scl_dram_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [15:0] coefAddr,
   input wire logic coefReady,
   output logic coefValid,
   output scl_pkg::scl_coef_t coefIn
);
   logic ready_q;
   scl_pkg::scl_coef_t word;

   // Slow mode: a dead cycle after each word, like a refresh gap
   always_ff @(posedge clk or posedge rst)
      if (rst)
         ready_q <= 1'b1;
      else
         ready_q <= !(coefValid && coefReady);

   // Per-position words; inverted while nothing is offered
   assign word = '{offset: {coefAddr[11:0], 4'h0}, gain: 16'h2000 + coefAddr};
   assign coefValid = !slow || ready_q;
   assign coefIn = coefValid ? word : ~word;
endmodule

// File: verification/scl_shading_correct_assertions.sv
// Port-level checks for the shading correction / line skip block.
// Bound to the top module from the bench; sees only its ports.
`timescale 1ns/100ps
module scl_shading_correct_assertions
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic lineStart,
   input wire logic pixValid,
   input wire logic pixReady,
   input wire logic [15:0] coefAddr,
   input wire logic coefValid,
   input wire logic coefReady,
   input wire logic outValid,
   input wire scl_pkg::scl_pix_t outPix,
   input wire logic outReady,
   input wire logic [4:0] lineSkipAux
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Address phases the slave takes, split by direction
   wire logic busTake = hsel && hready && htrans == scl_pkg::HTRANS_NONSEQ;
   wire logic rdTake = busTake && !hwrite;
   wire logic wrTake = busTake && hwrite;
   wire logic [9:0] idx = haddr[11:2];
   wire logic [4:0] auxIn = hwdata[7:3];

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Write data lands at the end of the data phase
   aux_update_a:
   assert property (wrTake && idx == scl_pkg::IDX_SKIP_AUX ##1 1'b1
      |=> lineSkipAux == $past(auxIn)) else $error("aux field not loaded");
   ofs_read_a:
   assert property (rdTake && idx == scl_pkg::IDX_OFS_HI
      |=> hrdata[31:8] == 24'h000000) else $error("offset byte too wide");
   gain_read_a:
   assert property (rdTake && idx == scl_pkg::IDX_GAIN_LO
      |=> hrdata[31:8] == 24'h000000) else $error("gain byte too wide");
   hole_read_a:
   assert property (rdTake && idx == 10'h3FF |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");
   pos_step_a:
   assert property (pixValid && pixReady
      |=> coefAddr == $past(coefAddr) + 16'h0001)
      else $error("pixel position did not step");
   pos_clear_a:
   assert property (lineStart |=> coefAddr == 16'h0000)
      else $error("pixel position not cleared");
   coef_pair_a:
   assert property (coefValid && coefReady |-> pixValid && pixReady)
      else $error("coefficient taken without a pixel");
   start_block_a:
   assert property (lineStart |-> !pixReady)
      else $error("pixel taken at line start");
   out_hold_a:
   assert property (outValid && !outReady |=> outValid && $stable(outPix))
      else $error("output changed before pop");

   // Main scenarios
   cover property (coefValid && coefReady);
   cover property (pixValid && !pixReady && !lineStart);
   cover property (outValid && outReady && outPix.lineFirst);
endmodule

// File: verification/scl_shading_correct_test.sv
// Self-checking bench: AHB-Lite master, pixel source and image sink.
// Coefficients come from the DRAM model; checker bound at the foot.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module scl_shading_correct_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic lineStart = 1'b0;
   logic pixValid = 1'b0;
   logic [15:0] pixData = 16'h0000;
   logic outReady = 1'b1;
   logic slow = 1'b0;
   logic hready, hresp, pixReady, coefValid, coefReady, outValid;
   logic [31:0] hrdata, rv;
   logic [15:0] coefAddr;
   logic [4:0] lineSkipAux;
   scl_pkg::scl_coef_t coefIn;
   scl_pkg::scl_pix_t outPix;
   scl_pkg::scl_pix_t got[$];
   int error_cnt = 0;
   int num_checks = 0;
   logic [7:0] cfgs[5] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h06};
   logic [7:0] skips[5][3] = '{'{8'hFF, 8'h03, 8'h02}, '{8'h00, 8'h03, 8'h06},
      '{8'hFF, 8'h00, 8'h06}, '{8'hFE, 8'h04, 8'h03}, '{8'h80, 8'h40, 8'h06}};

   scl_shading_correct u_scl_shading_correct (.clk, .rst, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp,
      .hrdata, .lineStart, .pixValid, .pixData, .pixReady, .coefAddr,
      .coefValid, .coefIn, .coefReady, .outValid, .outPix, .outReady,
      .lineSkipAux);
   scl_dram_model u_scl_dram_model (.clk, .rst, .slow, .coefAddr, .coefReady,
      .coefValid, .coefIn);

   always #5 clk = ~clk;

   // Image sink: collect every popped word
   always @(posedge clk)
      if (outValid && outReady)
         got.push_back(outPix);

   // One single-word transfer; read data lands in rv
   task automatic bus(input logic w, input logic [9:0] idx,
      input logic [7:0] wd);
      @(posedge clk);
      htrans <= scl_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {idx, 2'b00};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      do @(posedge clk); while (hready !== 1'b1);
      rv = hrdata;
   endtask

   // Line start pulse, then n pixels back to back
   task automatic line(input int n, input logic [15:0] base);
      @(posedge clk);
      lineStart <= 1'b1;
      @(posedge clk);
      lineStart <= 1'b0;
      pixValid <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         pixData <= base + 16'(i) * 16'h1F00;
         do @(posedge clk); while (pixReady !== 1'b1);
      end
      pixValid <= 1'b0;
   endtask

   task automatic drain();
      do @(posedge clk); while (outValid !== 1'b0);
   endtask

   function automatic logic [15:0] ex(input logic [15:0] p, o, g,
      input logic byp);
      logic [31:0] d;
      d = (p > o) ? 32'(p - o) : 32'h0;
      if (!byp)
         d = (d * 32'(g)) >> 14;
      return (d > 32'hFFFF) ? 16'hFFFF : d[15:0];
   endfunction

   // Fixed coefficients are 0x0100 and 0x8001 once written
   task automatic chk_line(input int n, input logic [15:0] base,
      input logic [7:0] cfg);
      scl_pkg::scl_pix_t e;
      scl_pkg::scl_pix_t g;
      logic [15:0] p;
      `CHK(got.size(), n)
      for (int i = 0; i < n; i++)
      begin
         p = base + 16'(i) * 16'h1F00;
         e.lineFirst = (i == 0);
         e.data = ex(p, cfg[2] ? 16'(i << 4) : 16'h0100,
            cfg[1] ? 16'h2000 + 16'(i) : 16'h8001, cfg[0]);
         // Pop once; the macro evaluates its operands twice on a miss
         g = got.pop_front();
         `CHK(g, e)
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, well beyond the few hundred cycles needed
   initial
   begin
      #400000;
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      hsel <= 1'b1;
      // ------------------------------------------------------------
      // Registers: reset values, readback, unmapped word
      // ------------------------------------------------------------
      bus(1'b0, scl_pkg::IDX_GAIN_HI, 8'h00);
      `CHK(rv, 32'h00000040)
      `CHK(hresp, 1'b0)
      bus(1'b0, scl_pkg::IDX_SRC_CFG, 8'h00);
      `CHK(rv, 32'h00000001)
      bus(1'b0, 10'h3FF, 8'h00);
      `CHK(rv, 32'h00000000)
      bus(1'b1, scl_pkg::IDX_OFS_HI, 8'h01);
      bus(1'b1, scl_pkg::IDX_OFS_LO, 8'h00);
      bus(1'b1, scl_pkg::IDX_GAIN_HI, 8'h80);
      bus(1'b1, scl_pkg::IDX_GAIN_LO, 8'h01);
      bus(1'b0, scl_pkg::IDX_OFS_HI, 8'h00);
      `CHK(rv, 32'h00000001)
      bus(1'b1, scl_pkg::IDX_SKIP_AUX, 8'hFF);
      bus(1'b0, scl_pkg::IDX_SKIP_AUX, 8'h00);
      `CHK(rv, 32'h000000F8)
      `CHK(lineSkipAux, 5'h1F)
      $display("test registers done");
      // Five source and bypass mixes; slow coefficients on odd runs
      for (int k = 0; k < 5; k++)
      begin
         bus(1'b1, scl_pkg::IDX_SRC_CFG, cfgs[k]);
         slow <= k[0];
         line(6, 16'h00C0);
         drain();
         chk_line(6, 16'h00C0, cfgs[k]);
      end
      $display("test correction done");
      // Line skipping: six lines of two pixels per setting
      bus(1'b1, scl_pkg::IDX_SRC_CFG, 8'h01);
      for (int k = 0; k < 5; k++)
      begin
         bus(1'b1, scl_pkg::IDX_KEEP_CNT, skips[k][0]);
         bus(1'b1, scl_pkg::IDX_SKIP_PER, skips[k][1]);
         got.delete();
         repeat (6) line(2, 16'h0200);
         drain();
         `CHK(got.size(), 2 * skips[k][2])
      end
      $display("test line skip done");
      // Sink stalls until the buffer refuses, then drains
      got.delete();
      outReady <= 1'b0;
      fork
         line(10, 16'h0300);
         begin
            repeat (40) @(posedge clk);
            bus(1'b0, scl_pkg::IDX_STATUS, 8'h00);
            `CHK(rv[scl_pkg::ST_FULL_BIT], 1'b1)
            outReady <= 1'b1;
         end
      join
      drain();
      chk_line(10, 16'h0300, 8'h01);
      $display("test buffer done");
      tally_and_finish();
   end
endmodule

bind scl_shading_correct scl_shading_correct_assertions u_chk (.clk, .rst,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .lineStart,
   .pixValid, .pixReady, .coefAddr, .coefValid, .coefReady, .outValid,
   .outPix, .outReady, .lineSkipAux);
